// File: inc/pbw_pkg.sv
// constants for the bridge window and control register block
// What this block does
// [R01] Base register bits 15:4 hold address 31:20; low 20 base bits decode as zero.
// [R02] Limit register bits 15:4 hold address 31:20; low 20 limit bits decode as ones.
// [R03] Base and limit read 000b in bits 3:1 and 1 in bit 0.
// [R04] Base upper bits 3:0 give address 35:32, reset all ones; 7:4 reserved.
// [R05] Limit upper bits 3:0 give address 35:32, reset zero; 7:4 reserved.
// [R06] Memory accesses between base and limit inclusive go to the link as prefetchable.
// [R07] Capability pointer is read-only and returns 50h.
// [R08] Interrupt line is a plain 8-bit store with no hardware effect.
// [R09] Interrupt pin is write-once; 01h..04h select INTA#..INTD#, others reserved.
// [R10] Secondary hot reset bit drives hot reset and holds link training in reset.
// [R11] After the bit clears and minimum time passes, both link ends go to detect.
// [R12] Secondary hot reset leaves these configuration registers unchanged.
// [R13] Video route enable sends legacy VGA I/O and memory accesses to this port.
// [R14] Software sets video route enable on at most one port; hardware does not check.
// [R15] Legacy gap enable sends I/O hits in last 768 bytes of each 1 KB to hub link.
// [R16] System error forward enable gates error messages from link to hub link.
// [R17] Poison response enable gates poisoned-packet reporting only; other errors stay reportable.
// [R18] Vendor command bit 3 set disables the completion timeout timer.
// [R19] Vendor command bit 1 set puts Enable Loopback in transmitted TS1 and TS2.
// [R20] Turn-off request is set by software, cleared on acknowledge or link down.
// [R21] Turn-off acknowledge sets on acknowledge while requested; cleared by write 1 or link down.
// [R22] Vendor status bit 1 mirrors the link active indication.
// [R23] Reserved and read-only bits ignore writes and read fixed values, zero if reserved.
package pbw_pkg;
	localparam int CFG_AW = 8;
	localparam int ADDR_W = 36;
	localparam int IO_AW = 16;
	// byte offsets in configuration space
	localparam logic [7:0] OFF_PBASE_LO = 8'h24;
	localparam logic [7:0] OFF_PBASE_HI = 8'h25;
	localparam logic [7:0] OFF_PLIM_LO = 8'h26;
	localparam logic [7:0] OFF_PLIM_HI = 8'h27;
	localparam logic [7:0] OFF_PBASE_UP = 8'h28;
	localparam logic [7:0] OFF_PLIM_UP = 8'h2C;
	localparam logic [7:0] OFF_CAPABILITY_LIST_POINTER = 8'h34;
	localparam logic [7:0] OFF_INT_LINE = 8'h3C;
	localparam logic [7:0] OFF_INT_PIN = 8'h3D;
	localparam logic [7:0] OFF_BCTL = 8'h3E;
	localparam logic [7:0] OFF_VCMD0 = 8'h44;
	localparam logic [7:0] OFF_VCMD1 = 8'h45;
	localparam logic [7:0] OFF_VSTS0 = 8'h46;
	localparam logic [7:0] OFF_VSTS1 = 8'h47;
	// reset and fixed values
	localparam logic [11:0] RST_PBASE = 12'hFFF;
	localparam logic [11:0] RST_PLIM = 12'h000;
	localparam logic [3:0] RST_PBASU = 4'hF;
	localparam logic [3:0] RST_PLMTU = 4'h0;
	localparam logic [7:0] RST_INT_PIN = 8'h02;
	localparam logic [3:0] WIN_LOW_BITS = 4'h1;
	localparam logic [7:0] CAPABILITY_LIST_POINTER_VAL = 8'h50;
	localparam logic [19:0] WIN_LOW_ONES = 20'hF_FFFF;
	localparam logic [19:0] WIN_LOW_ZERO = 20'h0_0000;
	// bridge control bit positions
	localparam int BC_PERR = 0;
	localparam int BC_SERR = 1;
	localparam int BC_ISA = 2;
	localparam int BC_VGA = 3;
	localparam int BC_SRST = 6;
	// vendor command and status bit positions
	localparam int VC_TOREQ = 0;
	localparam int VC_LPBK = 1;
	localparam int VC_CTO = 3;
	localparam int VS_TOACK = 0;
	localparam int VS_LINK = 1;
	// legacy video ranges
	localparam logic [ADDR_W-1:0] VGA_MEM_LO = 36'h0_000A_0000;
	localparam logic [ADDR_W-1:0] VGA_MEM_HI = 36'h0_000B_FFFF;
	localparam logic [IO_AW-1:0] VGA_IO1_LO = 16'h03B0;
	localparam logic [IO_AW-1:0] VGA_IO1_HI = 16'h03BB;
	localparam logic [IO_AW-1:0] VGA_IO2_LO = 16'h03C0;
	localparam logic [IO_AW-1:0] VGA_IO2_HI = 16'h03DF;
endpackage

// File: rtl/pbw_window_ctrl.sv
// bridge window decode, bridge control and vendor link control registers
`timescale 1ns/1ps
module pbw_window_ctrl #(
	parameter int HR_MIN_CYCLES = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// configuration access, one byte per access
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [pbw_pkg::CFG_AW-1:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	output logic cfg_rvalid,
	// processor memory and I/O requests
	input wire logic mem_req_valid,
	input wire logic [pbw_pkg::ADDR_W-1:0] mem_req_addr,
	input wire logic io_req_valid,
	input wire logic [pbw_pkg::IO_AW-1:0] io_req_addr,
	input wire logic io_in_window,
	output logic prefetch_fwd,
	output logic vga_mem_fwd,
	output logic io_to_port,
	output logic io_to_hub,
	// error messages from the link
	input wire logic serr_msg_rx,
	input wire logic poison_rx,
	output logic serr_to_hub,
	// link and transaction layer controls
	input wire logic link_active,
	input wire logic turn_off_ack_rx,
	output logic secondary_hot_reset,
	output logic completion_timeout_disable,
	output logic loopback_enable,
	output logic turn_off_request
);
	import pbw_pkg::*;

	localparam int CW = $clog2(HR_MIN_CYCLES + 1);
	localparam logic [CW-1:0] HR_LOAD = CW'(HR_MIN_CYCLES);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	typedef struct packed {
		logic [11:0] prefetch_window_base;
		logic [11:0] prefetch_window_limit;
		logic [3:0] prefetch_window_base_upper;
		logic [3:0] prefetch_window_limit_upper;
		logic [7:0] interrupt_line_number;
		logic [7:0] interrupt_pin_select;
		logic pin_locked;
		logic secondary_hot_reset_req;
		logic legacy_video_route_enable;
		logic legacy_io_gap_enable;
		logic system_error_forward_enable;
		logic poison_response_enable;
		logic cto_disable;
		logic loopback;
		logic turn_off_request;
		logic turn_off_acknowledge;
		logic [CW-1:0] hr_cnt;
		logic hot_reset;
		logic [7:0] rdata;
		logic rvalid;
		logic pf_fwd;
		logic vga_fwd;
		logic io_port;
		logic io_hub;
		logic serr_hub;
	} pbw_state_s;

	pbw_state_s st;
	pbw_state_s next_st;

	// --------------------------------------------------------------
	// read decode
	// --------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [CFG_AW-1:0] a, input pbw_state_s s, input logic lnk);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			OFF_PBASE_LO: d = {s.prefetch_window_base[3:0], WIN_LOW_BITS}; // R03
			OFF_PBASE_HI: d = s.prefetch_window_base[11:4]; // R01
			OFF_PLIM_LO: d = {s.prefetch_window_limit[3:0], WIN_LOW_BITS}; // R03
			OFF_PLIM_HI: d = s.prefetch_window_limit[11:4]; // R02
			OFF_PBASE_UP: d = {4'h0, s.prefetch_window_base_upper}; // R04
			OFF_PLIM_UP: d = {4'h0, s.prefetch_window_limit_upper}; // R05
			OFF_CAPABILITY_LIST_POINTER: d = CAPABILITY_LIST_POINTER_VAL; // R07
			OFF_INT_LINE: d = s.interrupt_line_number; // R08
			OFF_INT_PIN: d = s.interrupt_pin_select;
			OFF_BCTL: begin
				d[BC_SRST] = s.secondary_hot_reset_req;
				d[BC_VGA] = s.legacy_video_route_enable;
				d[BC_ISA] = s.legacy_io_gap_enable;
				d[BC_SERR] = s.system_error_forward_enable;
				d[BC_PERR] = s.poison_response_enable;
			end
			OFF_VCMD1: begin
				d[VC_CTO] = s.cto_disable;
				d[VC_LPBK] = s.loopback;
				d[VC_TOREQ] = s.turn_off_request;
			end
			OFF_VSTS1: begin
				d[VS_LINK] = lnk; // R22
				d[VS_TOACK] = s.turn_off_acknowledge;
			end
			// vendor command/status zero and unmapped bytes read zero
			default: d = 8'h00; // R23
		endcase
		return d;
	endfunction

	function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
		input logic [ADDR_W-1:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// --------------------------------------------------------------
	// window assembly
	// --------------------------------------------------------------
	logic [ADDR_W-1:0] win_base;
	logic [ADDR_W-1:0] win_limit;
	logic vga_io_hit;
	logic link_down;
	logic wr_bctl;
	logic wr_vcmd1;
	logic wr_vsts1;
	logic ack_event;

	always_comb begin
		win_base = {st.prefetch_window_base_upper, st.prefetch_window_base, WIN_LOW_ZERO}; // R01 R04
		win_limit = {st.prefetch_window_limit_upper, st.prefetch_window_limit, WIN_LOW_ONES}; // R02 R05
		vga_io_hit = ((io_req_addr >= VGA_IO1_LO) && (io_req_addr <= VGA_IO1_HI)) ||
			((io_req_addr >= VGA_IO2_LO) && (io_req_addr <= VGA_IO2_HI));
		link_down = !link_active;
		wr_bctl = cfg_wr && (cfg_addr == OFF_BCTL);
		wr_vcmd1 = cfg_wr && (cfg_addr == OFF_VCMD1);
		wr_vsts1 = cfg_wr && (cfg_addr == OFF_VSTS1);
		ack_event = st.turn_off_request && turn_off_ack_rx;
	end

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		next_st = st;
		// configuration writes; read-only and reserved bits are never stored
		if (cfg_wr) begin
			case (cfg_addr)
				OFF_PBASE_LO: next_st.prefetch_window_base[3:0] = cfg_wdata[7:4]; // R01 R23
				OFF_PBASE_HI: next_st.prefetch_window_base[11:4] = cfg_wdata; // R01
				OFF_PLIM_LO: next_st.prefetch_window_limit[3:0] = cfg_wdata[7:4]; // R02 R23
				OFF_PLIM_HI: next_st.prefetch_window_limit[11:4] = cfg_wdata; // R02
				OFF_PBASE_UP: next_st.prefetch_window_base_upper = cfg_wdata[3:0]; // R04
				OFF_PLIM_UP: next_st.prefetch_window_limit_upper = cfg_wdata[3:0]; // R05
				OFF_INT_LINE: next_st.interrupt_line_number = cfg_wdata; // R08
				OFF_INT_PIN: begin
					if (!st.pin_locked) begin
						next_st.interrupt_pin_select = cfg_wdata; // R09
						next_st.pin_locked = 1'b1; // R09
					end
				end
				OFF_BCTL: begin
					next_st.secondary_hot_reset_req = cfg_wdata[BC_SRST]; // R10
					next_st.legacy_video_route_enable = cfg_wdata[BC_VGA]; // R13
					next_st.legacy_io_gap_enable = cfg_wdata[BC_ISA]; // R15
					next_st.system_error_forward_enable = cfg_wdata[BC_SERR]; // R16
					next_st.poison_response_enable = cfg_wdata[BC_PERR]; // R17
				end
				OFF_VCMD1: begin
					next_st.cto_disable = cfg_wdata[VC_CTO]; // R18
					next_st.loopback = cfg_wdata[VC_LPBK]; // R19
				end
				default: begin
				end
			endcase
		end
		// turn-off handshake: software sets the request, hardware ends it
		if (wr_vcmd1 && cfg_wdata[VC_TOREQ]) begin
			next_st.turn_off_request = 1'b1; // R20
		end
		if (wr_vsts1 && cfg_wdata[VS_TOACK]) begin
			next_st.turn_off_acknowledge = 1'b0; // R21
		end
		// an acknowledge in the same cycle as a clearing write still lands
		if (ack_event) begin
			next_st.turn_off_acknowledge = 1'b1; // R21
			next_st.turn_off_request = 1'b0; // R20
		end
		if (link_down) begin
			next_st.turn_off_request = 1'b0; // R20
			next_st.turn_off_acknowledge = 1'b0; // R21
		end
		// hot reset: asserted the cycle after the bit sets, held at least the minimum time after assertion
		if (!st.hot_reset) begin
			if (st.secondary_hot_reset_req) begin
				next_st.hot_reset = 1'b1; // R10
				next_st.hr_cnt = HR_LOAD; // R11
			end
		end else begin
			if (st.hr_cnt != '0) begin
				next_st.hr_cnt = st.hr_cnt - CNT_ONE; // R11
			end else if (!st.secondary_hot_reset_req) begin
				next_st.hot_reset = 1'b0; // R11
			end
		end
		// configuration reads answer one cycle later
		next_st.rvalid = cfg_rd;
		next_st.rdata = cfg_rd ? read_byte(cfg_addr, st, link_active) : 8'h00;
		// request routing
		next_st.pf_fwd = mem_req_valid && in_range(mem_req_addr, win_base, win_limit); // R06
		next_st.vga_fwd = mem_req_valid && st.legacy_video_route_enable &&
			in_range(mem_req_addr, VGA_MEM_LO, VGA_MEM_HI); // R13
		next_st.io_port = 1'b0;
		next_st.io_hub = 1'b0;
		if (io_req_valid) begin
			if (st.legacy_video_route_enable && vga_io_hit) begin
				next_st.io_port = 1'b1; // R13
			end else if (io_in_window) begin
				if (st.legacy_io_gap_enable && (io_req_addr[9:8] != 2'b00)) begin
					next_st.io_hub = 1'b1; // R15
				end else begin
					next_st.io_port = 1'b1;
				end
			end else begin
				next_st.io_hub = 1'b1;
			end
		end
		// error forwarding toward the hub link
		next_st.serr_hub = st.system_error_forward_enable &&
			(serr_msg_rx || (poison_rx && st.poison_response_enable)); // R16 R17
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	// only arst_n resets this state; hot reset leaves it intact
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.prefetch_window_base <= RST_PBASE;
			st.prefetch_window_limit <= RST_PLIM;
			st.prefetch_window_base_upper <= RST_PBASU; // R04
			st.prefetch_window_limit_upper <= RST_PLMTU; // R05
			st.interrupt_pin_select <= RST_INT_PIN;
		end else begin
			st <= next_st; // R12
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign cfg_rdata = st.rdata;
	assign cfg_rvalid = st.rvalid;
	assign prefetch_fwd = st.pf_fwd;
	assign vga_mem_fwd = st.vga_fwd;
	assign io_to_port = st.io_port;
	assign io_to_hub = st.io_hub;
	assign serr_to_hub = st.serr_hub;
	assign secondary_hot_reset = st.hot_reset;
	assign completion_timeout_disable = st.cto_disable;
	assign loopback_enable = st.loopback;
	assign turn_off_request = st.turn_off_request;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	chk_window_hit: // R06
	assert property (mem_req_valid |=> prefetch_fwd ==
		(($past(mem_req_addr) >= {$past(st.prefetch_window_base_upper), $past(st.prefetch_window_base), 20'h0}) &&
		($past(mem_req_addr) <= {$past(st.prefetch_window_limit_upper), $past(st.prefetch_window_limit), 20'hFFFFF})))
		else $error("prefetch forward disagrees with window");
	chk_window_low_bits: // R03
	assert property (cfg_rd && (cfg_addr == OFF_PLIM_LO) |=> cfg_rvalid && (cfg_rdata[3:0] == 4'h1))
		else $error("limit low bits wrong");
	chk_capability_list_pointer_value: // R07
	assert property (cfg_rd && (cfg_addr == OFF_CAPABILITY_LIST_POINTER) |=> cfg_rvalid && (cfg_rdata == 8'h50))
		else $error("capability pointer wrong");
	chk_pin_write_once: // R09
	assert property (st.pin_locked && cfg_wr && (cfg_addr == OFF_INT_PIN) |=> $stable(st.interrupt_pin_select))
		else $error("interrupt pin written twice");
	chk_hot_reset_start: // R10
	assert property ($rose(st.secondary_hot_reset_req) |=> secondary_hot_reset)
		else $error("hot reset not driven");
	chk_hot_reset_min: // R11
	assert property ($rose(secondary_hot_reset) |-> secondary_hot_reset [*8])
		else $error("hot reset shorter than minimum");
	chk_ack_clears_req: // R21
	assert property (turn_off_request && turn_off_ack_rx && link_active |=> !turn_off_request && st.turn_off_acknowledge)
		else $error("acknowledge did not end request");
	chk_link_down_clear: // R20
	assert property (!link_active |=> !turn_off_request && !st.turn_off_acknowledge)
		else $error("link down did not clear handshake");
	chk_link_mirror: // R22
	assert property (cfg_rd && (cfg_addr == OFF_VSTS1) |=> cfg_rdata[1] == $past(link_active))
		else $error("link active not mirrored");
	chk_poison_gate: // R17
	assert property (poison_rx && !serr_msg_rx && !st.poison_response_enable |=> !serr_to_hub)
		else $error("poison reported while disabled");
	chk_serr_gate: // R16
	assert property (serr_msg_rx && st.system_error_forward_enable |=> serr_to_hub)
		else $error("error message not forwarded");
	chk_isa_gap: // R15
	assert property (io_req_valid && io_in_window && st.legacy_io_gap_enable && !st.legacy_video_route_enable &&
		(io_req_addr[9:8] != 2'b00) |=> io_to_hub && !io_to_port)
		else $error("legacy gap not sent to hub link");
	chk_reserved_upper: // R23
	assert property (cfg_rd && (cfg_addr == OFF_PBASE_UP) |=> cfg_rdata[7:4] == 4'h0)
		else $error("reserved bits not zero");
	chk_base_low_bits: // R03
	assert property (cfg_rd && (cfg_addr == OFF_PBASE_LO) |=> cfg_rvalid && (cfg_rdata[3:0] == 4'h1))
		else $error("base low bits wrong");
	chk_status_reserved: // R23
	assert property (cfg_rd && (cfg_addr == OFF_VSTS1) |=> cfg_rdata[7:2] == 6'h00)
		else $error("status reserved bits not zero");
	chk_line_store: // R08
	assert property (cfg_wr && (cfg_addr == OFF_INT_LINE) |=> st.interrupt_line_number == $past(cfg_wdata))
		else $error("interrupt line not stored");
	chk_upper_store: // R04
	assert property (cfg_wr && (cfg_addr == OFF_PBASE_UP) |=>
		st.prefetch_window_base_upper == $past(cfg_wdata[3:0]))
		else $error("base upper not stored");

	// --------------------------------------------------------------
	// checks: control and routing
	// --------------------------------------------------------------
	chk_bctl_store: // R10
	assert property (wr_bctl |=> (st.secondary_hot_reset_req == $past(cfg_wdata[BC_SRST])) &&
		(st.legacy_video_route_enable == $past(cfg_wdata[BC_VGA])) &&
		(st.legacy_io_gap_enable == $past(cfg_wdata[BC_ISA])))
		else $error("bridge control not stored");
	chk_vcmd_store: // R18
	assert property (wr_vcmd1 |=> (completion_timeout_disable == $past(cfg_wdata[VC_CTO])) &&
		(loopback_enable == $past(cfg_wdata[VC_LPBK])))
		else $error("vendor command not stored");
	chk_request_set: // R20
	assert property (wr_vcmd1 && cfg_wdata[VC_TOREQ] && link_active && !turn_off_request |=> turn_off_request)
		else $error("turn-off request not set");
	chk_ack_set_wins: // R21
	assert property (wr_vsts1 && cfg_wdata[VS_TOACK] && ack_event && link_active |=> st.turn_off_acknowledge)
		else $error("clear beat the acknowledge");
	chk_vga_mem_route: // R13
	assert property (mem_req_valid && st.legacy_video_route_enable && (mem_req_addr >= VGA_MEM_LO) &&
		(mem_req_addr <= VGA_MEM_HI) |=> vga_mem_fwd)
		else $error("video memory not routed");
	chk_vga_mem_off: // R13
	assert property (mem_req_valid && !st.legacy_video_route_enable |=> !vga_mem_fwd)
		else $error("video memory routed while off");
	chk_io_one_route: // R15
	assert property (io_req_valid |=> io_to_port != io_to_hub)
		else $error("I/O routing not exclusive");

	// --------------------------------------------------------------
	// checks: hot reset timing
	// --------------------------------------------------------------
	chk_hot_reset_hold: // R10
	assert property (secondary_hot_reset && st.secondary_hot_reset_req |=> secondary_hot_reset)
		else $error("hot reset dropped while bit set");
	chk_hot_reset_load: // R11
	assert property ($rose(secondary_hot_reset) |-> st.hr_cnt == HR_LOAD)
		else $error("hot reset timer not loaded");
	chk_hot_reset_end: // R11
	assert property ($fell(secondary_hot_reset) |->
		($past(st.hr_cnt) == '0) && !$past(st.secondary_hot_reset_req))
		else $error("hot reset ended early");

	cov_prefetch_hit: cover property (prefetch_fwd);
	cov_turn_off_done: cover property (turn_off_request ##[1:20] st.turn_off_acknowledge);
	cov_hot_reset_cycle: cover property ($rose(secondary_hot_reset) ##[1:100] $fell(secondary_hot_reset));
	cov_isa_hub: cover property (io_to_hub && st.legacy_io_gap_enable);
	cov_ack_set_wins: cover property (wr_vsts1 && cfg_wdata[VS_TOACK] && ack_event);
endmodule

// File: test/pbw_link_model.sv
// behavioural link layer and downstream device facing the bridge port
`timescale 1ns/1ps
module pbw_link_model #(
	parameter int TRAIN_CYCLES = 6
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// controls from the bridge
	input wire logic secondary_hot_reset,
	input wire logic turn_off_request,
	// link status and messages
	output logic link_active,
	output logic turn_off_ack_rx,
	output logic serr_msg_rx,
	output logic poison_rx
);
	logic up_cmd = 1;
	logic ack_en = 1;
	int ack_delay = 3;
	int train = TRAIN_CYCLES;
	int wait_cnt = 0;
	initial begin
		link_active = 0;
		turn_off_ack_rx = 0;
		serr_msg_rx = 0;
		poison_rx = 0;
	end
	// hot reset holds training in reset, then both ends detect and retrain
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n || secondary_hot_reset || !up_cmd) begin
			link_active <= 0;
			train <= TRAIN_CYCLES;
		end else if (train != 0) begin
			train <= train - 1;
		end else begin
			link_active <= 1;
		end
	end
	// slow acknowledge of a pending turn-off request
	always @(posedge ref_clk or negedge arst_n) begin
		turn_off_ack_rx <= 0;
		if (!arst_n || turn_off_request !== 1 || !ack_en) begin
			wait_cnt <= 0;
		end else if (wait_cnt == ack_delay) begin
			turn_off_ack_rx <= link_active;
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	task automatic send_err(input logic s, input logic p);
		@(posedge ref_clk);
		serr_msg_rx <= s;
		poison_rx <= p;
		@(posedge ref_clk);
		serr_msg_rx <= 0;
		poison_rx <= 0;
	endtask
endmodule

// File: test/test_pbw_window_ctrl.sv
// self-checking bench for the bridge window control register block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_pbw_window_ctrl;
	import pbw_pkg::*;
	localparam int HR = 8;
	logic ref_clk = 0;
	logic arst_n = 0;
	logic cfg_wr = 0;
	logic cfg_rd = 0;
	logic [CFG_AW-1:0] cfg_addr = '0;
	logic [7:0] cfg_wdata = '0;
	logic mem_req_valid = 0;
	logic [ADDR_W-1:0] mem_req_addr = '0;
	logic io_req_valid = 0;
	logic [IO_AW-1:0] io_req_addr = '0;
	logic io_in_window = 0;
	logic [7:0] cfg_rdata;
	logic cfg_rvalid, prefetch_fwd, vga_mem_fwd, io_to_port, io_to_hub, serr_to_hub;
	logic serr_msg_rx, poison_rx, link_active, turn_off_ack_rx;
	logic secondary_hot_reset, completion_timeout_disable, loopback_enable, turn_off_request;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int hr_cnt = 0;
	pbw_window_ctrl #(.HR_MIN_CYCLES(HR)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr), .io_req_valid(io_req_valid),
		.io_req_addr(io_req_addr), .io_in_window(io_in_window), .prefetch_fwd(prefetch_fwd),
		.vga_mem_fwd(vga_mem_fwd), .io_to_port(io_to_port), .io_to_hub(io_to_hub), .serr_msg_rx(serr_msg_rx),
		.poison_rx(poison_rx), .serr_to_hub(serr_to_hub), .link_active(link_active),
		.turn_off_ack_rx(turn_off_ack_rx), .secondary_hot_reset(secondary_hot_reset),
		.completion_timeout_disable(completion_timeout_disable), .loopback_enable(loopback_enable),
		.turn_off_request(turn_off_request));
	pbw_link_model link (.ref_clk(ref_clk), .arst_n(arst_n), .secondary_hot_reset(secondary_hot_reset),
		.turn_off_request(turn_off_request), .link_active(link_active), .turn_off_ack_rx(turn_off_ack_rx),
		.serr_msg_rx(serr_msg_rx), .poison_rx(poison_rx));
	always #10 ref_clk = ~ref_clk;
	// cycle counter for the hang limit and hot reset length
	always @(posedge ref_clk) begin
		cyc++;
		if (secondary_hot_reset === 1)
			hr_cnt++;
		if (cyc == 5000) begin
			mismatches++;
			$display("CHECK FAILED t=%0t timeout", $time);
			end_of_test();
		end
	end
	// ----------------------------------------
	// bus and request tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cfg_wr <= 1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge ref_clk);
		cfg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		cfg_rd <= 1;
		cfg_addr <= a;
		@(posedge ref_clk);
		cfg_rd <= 0;
		#1;
		`CHK({cfg_rvalid, cfg_rdata}, {1'b1, e})
	endtask
	task automatic mem(input logic [ADDR_W-1:0] a, input logic [1:0] e);
		@(posedge ref_clk);
		mem_req_valid <= 1;
		mem_req_addr <= a;
		@(posedge ref_clk);
		mem_req_valid <= 0;
		#1;
		`CHK({prefetch_fwd, vga_mem_fwd}, e)
	endtask
	task automatic io(input logic [IO_AW-1:0] a, input logic w, input logic [1:0] e);
		@(posedge ref_clk);
		io_req_valid <= 1;
		io_req_addr <= a;
		io_in_window <= w;
		@(posedge ref_clk);
		io_req_valid <= 0;
		#1;
		`CHK({io_to_port, io_to_hub}, e)
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [7:0] ra [14] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2C, 8'h34, 8'h3C, 8'h3D, 8'h44, 8'h45, 8'h46,
			8'h3E, 8'h30};
		logic [7:0] rv [14] = '{8'hF1, 8'hFF, 8'h01, 8'h00, 8'h0F, 8'h00, 8'h50, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		logic [7:0] wd [14] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hF4, 8'hFF,
			8'hB0, 8'hFF};
		logic [7:0] wv [14] = '{8'hF1, 8'hFF, 8'hF1, 8'hFF, 8'h0F, 8'h0F, 8'h50, 8'hFF, 8'h03, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		for (int i = 0; i < 14; i++)
			rd(ra[i], rv[i]);
		for (int i = 0; i < 14; i++) begin
			wr(ra[i], wd[i]);
			rd(ra[i], wv[i]);
		end
		wr(8'h3D, 8'h01);
		rd(8'h3D, 8'h03);
		for (int k = 0; k < 50 && link_active !== 1; k++) @(posedge ref_clk);
		wr(8'h47, 8'hFC);
		rd(8'h47, 8'h02);
		$display("register access test done");
	endtask
	task automatic t_window();
		wr(8'h24, 8'h00);
		wr(8'h25, 8'h10);
		wr(8'h28, 8'h01);
		wr(8'h26, 8'hF0);
		wr(8'h27, 8'h1F);
		wr(8'h2C, 8'h01);
		mem(36'h1_1000_0000, 2'b10);
		mem(36'h1_0FFF_FFFF, 2'b00);
		mem(36'h1_1FFF_FFFF, 2'b10);
		mem(36'h1_2000_0000, 2'b00);
		mem(36'h0_1000_0000, 2'b00);
		mem(36'h2_1000_0000, 2'b00);
		mem(36'h0_000A_0000, 2'b00);
		$display("window decode test done");
	endtask
	task automatic t_route();
		// only this port routes legacy video
		wr(8'h3E, 8'h08);
		mem(36'h0_000A_0000, 2'b01);
		mem(36'h0_000B_FFFF, 2'b01);
		mem(36'h0_000C_0000, 2'b00);
		io(16'h03B0, 1'b0, 2'b10);
		io(16'h03BC, 1'b0, 2'b01);
		io(16'h03DF, 1'b0, 2'b10);
		wr(8'h3E, 8'h04);
		io(16'h0100, 1'b1, 2'b01);
		io(16'h03FF, 1'b1, 2'b01);
		io(16'h0400, 1'b1, 2'b10);
		io(16'h00FF, 1'b1, 2'b10);
		io(16'h0100, 1'b0, 2'b01);
		wr(8'h3E, 8'h00);
		io(16'h0100, 1'b1, 2'b10);
		$display("routing test done");
	endtask
	task automatic t_errors();
		for (int i = 0; i < 16; i++) begin
			wr(8'h3E, {6'h00, i[3:2]});
			link.send_err(i[1], i[0]);
			#1;
			`CHK(serr_to_hub, i[3] & (i[1] | (i[0] & i[2])))
		end
		$display("error forwarding test done");
	endtask
	task automatic t_vendor();
		wr(8'h45, 8'h0A);
		#1;
		`CHK({completion_timeout_disable, loopback_enable, turn_off_request}, 3'b110)
		wr(8'h45, 8'h08);
		#1;
		`CHK({completion_timeout_disable, loopback_enable}, 2'b10)
		wr(8'h45, 8'h00);
		#1;
		`CHK(completion_timeout_disable, 1'b0)
		wr(8'h45, 8'h01);
		#1;
		`CHK(turn_off_request, 1'b1)
		for (int k = 0; k < 20 && turn_off_request !== 0; k++) @(posedge ref_clk);
		rd(8'h47, 8'h03);
		rd(8'h45, 8'h00);
		// new request; its acknowledge meets a clearing write on the same edge
		wr(8'h45, 8'h01);
		repeat (3) @(posedge ref_clk);
		wr(8'h47, 8'h01);
		rd(8'h47, 8'h03);
		wr(8'h47, 8'h01);
		rd(8'h47, 8'h02);
		link.ack_en <= 0;
		wr(8'h47, 8'h00);
		wr(8'h45, 8'h01);
		link.up_cmd <= 0;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(turn_off_request, 1'b0)
		rd(8'h47, 8'h00);
		link.up_cmd <= 1;
		link.ack_en <= 1;
		$display("vendor control test done");
	endtask
	task automatic t_hot_reset();
		hr_cnt = 0;
		wr(8'h3E, 8'h40);
		rd(8'h25, 8'h10);
		#1;
		`CHK(secondary_hot_reset, 1'b1)
		rd(8'h28, 8'h01);
		wr(8'h3E, 8'h00);
		repeat (HR + 6) @(posedge ref_clk);
		#1;
		`CHK(hr_cnt >= HR + 1 && hr_cnt <= HR + 3, 1'b1)
		for (int k = 0; k < 50 && link_active !== 1; k++) @(posedge ref_clk);
		rd(8'h47, 8'h02);
		$display("hot reset test done");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1;
		t_regs();
		t_window();
		t_route();
		t_errors();
		t_vendor();
		t_hot_reset();
		end_of_test();
	end
endmodule
